// >>> core/host_bus_ack_and_user_pins.sv
// Bus ownership handshake, slave acknowledge, master cycle termination
// and user pins of a network controller system bus port.
// Assumes one clock, synchronous pins, AHB-Lite register access.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "host_bus_ack_map.svh"

module host_bus_ack_and_user_pins (
   input  wire logic                          i_ref_clk,
   input  wire logic                          i_rst,
   // AHB-Lite slave
   input  wire logic                          i_hsel,
   input  wire logic [31:0]                   i_haddr,
   input  wire logic [1:0]                    i_htrans,
   input  wire logic                          i_hwrite,
   input  wire logic [2:0]                    i_hsize,
   input  wire logic [31:0]                   i_hwdata,
   input  wire logic                          i_hready,
   output logic      [31:0]                   o_hrdata,
   output logic                               o_hreadyout,
   output logic                               o_hresp,
   // Arbitration
   input  wire logic                          i_bus_grant_in_n,
   input  wire logic                          i_address_strobe_n,
   input  wire logic                          i_grant_acknowledge_n,
   input  wire logic                          i_hold_acknowledge,
   output logic                               o_bus_request_n,
   output logic                               o_bus_request_oe,
   output logic                               o_grant_acknowledge_n,
   output logic                               o_grant_acknowledge_oe,
   output logic                               o_address_strobe_n,
   output logic                               o_address_strobe_oe,
   // Size acknowledges
   input  wire host_bus_ack_pkg::size_ack_s   i_size_ack,
   output host_bus_ack_pkg::size_ack_s        o_size_ack,
   output logic                               o_size_ack_oe,
   // Slave register port
   input  wire logic                          i_chip_select_n,
   input  wire logic                          i_slave_direction,
   input  wire logic [1:0]                    i_reg_index,
   input  wire logic [15:0]                   i_data,
   output logic      [31:0]                   o_data,
   output logic                               o_data_oe,
   // User pins
   input  wire logic [1:0]                    i_user_pins,
   output logic      [1:0]                    o_user_pins,
   output logic                               o_user_pins_oe
);
   import host_bus_ack_pkg::*;

   master_e     m_q, m_d;
   slave_e      s_q, s_d;
   logic [15:0] cfg_q, cfg_d;
   logic        req_q, req_d;
   logic        go_q, go_d;
   logic [7:0]  cnt_q, cnt_d;
   logic [1:0]  ad_idx_q, ad_idx_d;
   logic        ad_wr_q, ad_wr_d, ad_rd_q, ad_rd_d;
   logic        ad_ok_q, ad_ok_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic        hready_q, hready_d;
   logic        br_n_q, br_n_d, br_oe_q, br_oe_d;
   logic        gack_n_q, gack_n_d, gack_oe_q, gack_oe_d;
   logic        as_n_q, as_n_d, as_oe_q, as_oe_d;
   size_ack_s   sack_q, sack_d;
   logic        sack_oe_q, sack_oe_d;
   logic [31:0] data_q, data_d;
   logic        data_oe_q, data_oe_d;
   logic [1:0]  usr_q, usr_d;
   logic        usr_oe_q, usr_oe_d;
   size_ack_s   sync1_q, sync2_q;
   size_ack_s   samp;
   logic        ack_ok, owned, bus_free, ahb_wr, slv_wr;

   // Register read mux, shared by the bus and the slave pins
   function automatic logic [15:0] reg_word(input logic [1:0] idx);
      logic [15:0] w;
      w = 16'h0000;
      if (idx == 2'(`OFS_CFG >> 2)) begin
         w = cfg_q;
      end else if (idx == 2'(`OFS_CTRL >> 2)) begin
         w[`CTRL_REQ] = req_q;
      end else if (idx == 2'(`OFS_STAT >> 2)) begin
         w[`STAT_OWNED] = owned;
         w[`STAT_CYCLE] = (m_q == M_CYC);
         w[`STAT_CNT_LSB +: 8] = cnt_q;
      end
      return w;
   endfunction : reg_word

   // Two-stage synchroniser for the asynchronous sampling option
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         sync1_q <= 2'b11;
         sync2_q <= 2'b11;
      end else begin
         sync1_q <= i_size_ack;
         sync2_q <= sync1_q;
      end
   end

   // Sampling path and termination condition per bus size
   always_comb begin
      samp   = cfg_q[`CFG_SYNC] ? i_size_ack : sync2_q;
      ack_ok = cfg_q[`CFG_BUS32] ?
               (!samp.low_n && !samp.high_n) :
               !samp.high_n;
      owned  = (m_q == M_OWN) || (m_q == M_CYC);
      bus_free = i_address_strobe_n && samp.low_n &&
                 samp.high_n && i_grant_acknowledge_n;
   end

   // AHB-Lite front end; reads insert one wait state so that a write
   // just before is already visible
   always_comb begin
      ad_idx_d = ad_idx_q;
      ad_wr_d  = 1'b0;
      ad_rd_d  = 1'b0;
      ad_ok_d  = ad_ok_q;
      hready_d = 1'b1;
      hrdata_d = hrdata_q;
      if (ad_rd_q && !hready_q) begin
         hrdata_d = ad_ok_q ? {16'h0000, reg_word(ad_idx_q)} : 32'h0;
      end
      if (i_hsel && i_htrans[1] && i_hready) begin
         ad_idx_d = i_haddr[3:2];
         ad_ok_d  = (i_haddr[3:2] != 2'b11) && (i_haddr[1:0] == 2'b00);
         ad_wr_d  = i_hwrite;
         ad_rd_d  = !i_hwrite;
         hready_d = i_hwrite;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ad_idx_q <= 2'b00;
         ad_wr_q  <= 1'b0;
         ad_rd_q  <= 1'b0;
         ad_ok_q  <= 1'b0;
         hready_q <= 1'b1;
         hrdata_q <= 32'h0;
      end else begin
         ad_idx_q <= ad_idx_d;
         ad_wr_q  <= ad_wr_d;
         ad_rd_q  <= ad_rd_d && !hready_d ? 1'b1 : (hready_q ? ad_rd_d : 1'b0);
         ad_ok_q  <= ad_ok_d;
         hready_q <= hready_d;
         hrdata_q <= hrdata_d;
      end
   end

   // Registers; the bus wins over a slave pin write in the same cycle
   always_comb begin
      ahb_wr = ad_wr_q && ad_ok_q;
      slv_wr = (s_q == S_IDLE) && (s_d == S_ACK) && !i_slave_direction;
      cfg_d  = cfg_q;
      req_d  = req_q;
      go_d   = go_q;
      cnt_d  = cnt_q;
      if ((m_q == M_OWN) && go_q) begin
         go_d = 1'b0;
      end
      if ((m_q == M_CYC) && ack_ok) begin
         cnt_d = cnt_q + 8'h01;
      end
      if (ahb_wr && ad_idx_q == 2'(`OFS_CFG >> 2)) begin
         cfg_d = (cfg_q & ~`CFG_WMASK) | (i_hwdata[15:0] & `CFG_WMASK);
      end else if (ahb_wr && ad_idx_q == 2'(`OFS_CTRL >> 2)) begin
         req_d = i_hwdata[`CTRL_REQ];
         go_d  = go_d | i_hwdata[`CTRL_GO];   // Set beats the consume
      end else if (slv_wr && i_reg_index == 2'(`OFS_CFG >> 2)) begin
         cfg_d = (cfg_q & ~`CFG_WMASK) | (i_data & `CFG_WMASK);
      end
      // Pins feed bits 8 and 9 while held; last level stays at release
      if (i_rst) begin
         cfg_d = `CFG_RST;
         cfg_d[`CFG_USR_IN0] = i_user_pins[0];
         cfg_d[`CFG_USR_IN1] = i_user_pins[1];
         req_d = 1'b0;
         go_d  = 1'b0;
         cnt_d = 8'h00;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      cfg_q <= cfg_d;
      req_q <= req_d;
      go_q  <= go_d;
      cnt_q <= cnt_d;
   end

   // Master side: request, claim, memory cycle, release
   always_comb begin
      m_d       = m_q;
      br_n_d    = br_n_q;
      br_oe_d   = br_oe_q;
      gack_n_d  = gack_n_q;
      gack_oe_d = gack_oe_q;
      as_n_d    = as_n_q;
      as_oe_d   = as_oe_q;
      case (m_q)
         M_IDLE: begin
            if (req_q && (s_q == S_IDLE)) begin
               m_d     = M_REQ;
               br_n_d  = 1'b0;
               br_oe_d = 1'b1;
            end
         end
         M_REQ: begin
            if (!req_q) begin
               m_d     = M_IDLE;
               br_n_d  = 1'b1;
               br_oe_d = 1'b0;
            end else if (!i_bus_grant_in_n && bus_free) begin
               m_d       = M_OWN;
               br_n_d    = 1'b1;
               br_oe_d   = 1'b0;
               gack_n_d  = 1'b0;
               gack_oe_d = 1'b1;
               as_n_d    = 1'b1;
               as_oe_d   = 1'b1;
            end
         end
         M_OWN: begin
            if (go_q) begin
               m_d    = M_CYC;
               as_n_d = 1'b0;
            end else if (!req_q) begin
               m_d       = M_IDLE;
               gack_n_d  = 1'b1;
               gack_oe_d = 1'b0;
               as_oe_d   = 1'b0;
            end
         end
         M_CYC: begin
            if (ack_ok) begin
               m_d    = M_OWN;
               as_n_d = 1'b1;
            end
         end
         default: m_d = M_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         m_q       <= M_IDLE;
         br_n_q    <= 1'b1;
         br_oe_q   <= 1'b0;
         gack_n_q  <= 1'b1;
         gack_oe_q <= 1'b0;
         as_n_q    <= 1'b1;
         as_oe_q   <= 1'b0;
      end else begin
         m_q       <= m_d;
         br_n_q    <= br_n_d;
         br_oe_q   <= br_oe_d;
         gack_n_q  <= gack_n_d;
         gack_oe_q <= gack_oe_d;
         as_n_q    <= as_n_d;
         as_oe_q   <= as_oe_d;
      end
   end

   // Slave side; not answered while we own the bus, acks are inputs then
   always_comb begin
      s_d       = s_q;
      sack_d    = sack_q;
      sack_oe_d = sack_oe_q;
      data_d    = data_q;
      data_oe_d = data_oe_q;
      case (s_q)
         S_IDLE: begin
            if (!i_chip_select_n && (m_q == M_IDLE)) begin
               s_d       = S_ACK;
               sack_d    = 2'b00;
               sack_oe_d = 1'b1;
               // Upper half driven as zero and carries no meaning
               data_d    = {16'h0000, reg_word(i_reg_index)};
               data_oe_d = i_slave_direction;
            end
         end
         S_ACK: begin
            if (i_chip_select_n) begin
               s_d       = S_IDLE;
               sack_d    = 2'b11;
               sack_oe_d = 1'b0;
               data_oe_d = 1'b0;
            end
         end
         default: s_d = S_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         s_q       <= S_IDLE;
         sack_q    <= 2'b11;
         sack_oe_q <= 1'b0;
         data_q    <= 32'h0;
         data_oe_q <= 1'b0;
      end else begin
         s_q       <= s_d;
         sack_q    <= sack_d;
         sack_oe_q <= sack_oe_d;
         data_q    <= data_d;
         data_oe_q <= data_oe_d;
      end
   end

   // User pins driven only while this end or a hold owns the bus
   always_comb begin
      usr_oe_d = owned || i_hold_acknowledge;
      usr_d    = {cfg_q[`CFG_USR_OUT1], cfg_q[`CFG_USR_OUT0]};
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         usr_q    <= 2'b00;
         usr_oe_q <= 1'b0;
      end else begin
         usr_q    <= usr_d;
         usr_oe_q <= usr_oe_d;
      end
   end

   // Outputs straight from their flops; o_hresp tied to zero
   assign o_hrdata               = hrdata_q;
   assign o_hreadyout            = hready_q;
   assign o_hresp                = 1'b0;
   assign o_bus_request_n        = br_n_q;
   assign o_bus_request_oe       = br_oe_q;
   assign o_grant_acknowledge_n  = gack_n_q;
   assign o_grant_acknowledge_oe = gack_oe_q;
   assign o_address_strobe_n     = as_n_q;
   assign o_address_strobe_oe    = as_oe_q;
   assign o_size_ack             = sack_q;
   assign o_size_ack_oe          = sack_oe_q;
   assign o_data                 = data_q;
   assign o_data_oe              = data_oe_q;
   assign o_user_pins            = usr_q;
   assign o_user_pins_oe         = usr_oe_q;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   a_claim_after_grant: assert property (
      $fell(o_grant_acknowledge_n) |-> $past(!i_bus_grant_in_n))
      else $error("grant acknowledge without bus grant");
   a_claim_bus_free: assert property (
      $fell(o_grant_acknowledge_n) |-> $past(bus_free))
      else $error("bus claimed while previous owner active");
   a_slave_ack_pair: assert property (
      o_size_ack_oe |-> o_size_ack == 2'b00)
      else $error("slave acknowledges not driven low together");
   a_slave_read_data: assert property (
      $rose(o_data_oe) |-> o_size_ack_oe && o_data[31:16] == 16'h0000)
      else $error("slave read data without acknowledge");
   a_end_cycle_32: assert property (
      $rose(o_address_strobe_n) && cfg_q[`CFG_BUS32] && !$past(i_rst)
      |-> $past(samp == 2'b00))
      else $error("32-bit cycle ended without both acks");
   a_end_cycle_16: assert property (
      $rose(o_address_strobe_n) && !cfg_q[`CFG_BUS32] && !$past(i_rst)
      |-> $past(!samp.high_n))
      else $error("16-bit cycle ended without high ack");
   a_async_sample: assert property (
      !cfg_q[`CFG_SYNC] && $past(i_rst, 2) == 1'b0 && !$past(i_rst)
      |-> samp == $past(i_size_ack, 2))
      else $error("asynchronous ack path not two stages");
   a_user_latch: assert property (
      $fell(i_rst) |=> cfg_q[9:8] == $past(i_user_pins, 2))
      else $error("user pin levels not latched at reset release");
   a_user_drive: assert property (
      owned |=> o_user_pins_oe &&
      o_user_pins == {$past(cfg_q[12]), $past(cfg_q[11])})
      else $error("user pins not driven while owning");
   a_user_float: assert property (
      !owned && !i_hold_acknowledge |=> !o_user_pins_oe)
      else $error("user pins driven outside mastership");

endmodule : host_bus_ack_and_user_pins

// >>> core/host_bus_ack_map.svh
// Register offsets, field positions, reset values and the write mask for the
// host bus acknowledge and user pin block.
// Assumes one 32-bit AHB-Lite slave port, words at aligned byte offsets.
//
// Summary of operation
// - Claim the bus with grant acknowledge only after bus grant arrives.
// - Claim only when address strobe, both size acks, prior grant ack idle.
// - Slave access ends by driving both size acknowledges low together.
// - Slave read data valid on low sixteen lines; upper lines driven too.
// - As master, end each memory cycle only after required acknowledge.
// - In 32-bit master mode both size acknowledges must be active.
// - In 16-bit master mode the high acknowledge alone ends the cycle.
// - Size acks sampled directly or through synchronisers per config bit.
// - No dynamic sizing; master width set only by bus size config bit.
// - During hard reset the user pins are inputs feeding config bits 8, 9.
// - User pin levels are latched at reset release and then held.
// - While owning the bus, user pins output config bits 11 and 12.
`ifndef HOST_BUS_ACK_MAP_SVH
`define HOST_BUS_ACK_MAP_SVH

// Byte offsets
`define OFS_CFG        4'h0
`define OFS_CTRL       4'h4
`define OFS_STAT       4'h8

// Data configuration fields
`define CFG_BUS32      5
`define CFG_USR_IN0    8
`define CFG_USR_IN1    9
`define CFG_SYNC       10
`define CFG_USR_OUT0   11
`define CFG_USR_OUT1   12
`define CFG_RST        16'h0000
`define CFG_WMASK      16'hfcff

// Control and status fields
`define CTRL_REQ       0
`define CTRL_GO        1
`define STAT_OWNED     0
`define STAT_CYCLE     1
`define STAT_CNT_LSB   8

`endif

// >>> core/host_bus_ack_pkg.sv
// Types shared by the host bus acknowledge block.
// Assumes the map header supplies all numbers.
package host_bus_ack_pkg;

   // Pair of size acknowledge lines, both active low
   typedef struct packed {
      logic high_n;
      logic low_n;
   } size_ack_s;

   typedef enum logic [3:0] {
      M_IDLE = 4'b0001,
      M_REQ  = 4'b0010,
      M_OWN  = 4'b0100,
      M_CYC  = 4'b1000
   } master_e;

   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_ACK  = 2'b10
   } slave_e;

endpackage : host_bus_ack_pkg

// >>> bench/bus_side_model.sv
// Partner model: system bus arbiter and the memory slave of master cycles.
// Assumes pull-ups on the grant and size acknowledge lines.
`timescale 1ns/100ps

module bus_side_model (
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_bus_request_n,
   input  wire logic                   i_address_strobe_n,
   input  wire logic [1:0]             i_ack_mode,
   output logic                        o_bus_grant_n,
   output host_bus_ack_pkg::size_ack_s o_size_ack
);
   import host_bus_ack_pkg::*;

   logic [1:0] req_cnt;

   // Grant four cycles after a request, dropped with the request
   always_ff @(posedge i_ref_clk) begin
      if (i_bus_request_n) begin
         req_cnt       <= 2'h0;
         o_bus_grant_n <= 1'b1;
      end else if (req_cnt != 2'h3) begin
         req_cnt <= req_cnt + 2'h1;
      end else begin
         o_bus_grant_n <= 1'b0;
      end
   end

   // Acks only inside a strobe; mode bit 1 is the high line, bit 0 the low
   // Mode 00 stalls the slave until the bench changes it
   always_ff @(posedge i_ref_clk) begin
      if (i_address_strobe_n) begin
         o_size_ack <= 2'b11;
      end else begin
         o_size_ack <= ~i_ack_mode;
      end
   end

endmodule : bus_side_model

// >>> bench/tb_host_bus_ack_and_user_pins.sv
// Self-checking bench for the host bus acknowledge and user pin block.
// Assumes the bus side model and a set pull level on every shared line.
`timescale 1ns/100ps
`include "host_bus_ack_map.svh"

module tb_host_bus_ack_and_user_pins;
   import host_bus_ack_pkg::*;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        cs_n = 1'b1;
   logic        dir = 1'b1;
   logic        other_gack_n = 1'b1;
   logic        hold_ack = 1'b0;
   logic [1:0]  pulls = 2'b10;
   logic [1:0]  ack_mode = 2'b00;
   logic [15:0] sdata = 16'h0;
   logic [31:0] hrdata, odata;
   logic        hready, hresp, br_n, br_oe, gack_n, gack_oe, as_n, as_oe;
   logic        grant_n, sa_oe, data_oe, upins_oe, as_bus, br_bus;
   logic [1:0]  upins, upin_bus;
   size_ack_s   sa_dut, sa_mdl, sa_bus;
   int          err_total = 0;
   int          check_count = 0;

   always #50 clk = ~clk;

   // Wired bus levels; undriven lines float to their pull level
   assign br_bus   = br_oe ? br_n : 1'b1;
   assign as_bus   = as_oe ? as_n : 1'b1;
   assign sa_bus   = sa_oe ? (sa_dut & sa_mdl) : sa_mdl;
   assign upin_bus = upins_oe ? upins : pulls;

   host_bus_ack_and_user_pins DUT (
      .i_ref_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
      .o_hreadyout(hready), .o_hresp(hresp),
      .i_bus_grant_in_n(grant_n), .i_address_strobe_n(as_bus),
      .i_grant_acknowledge_n(other_gack_n), .i_hold_acknowledge(hold_ack),
      .o_bus_request_n(br_n), .o_bus_request_oe(br_oe),
      .o_grant_acknowledge_n(gack_n), .o_grant_acknowledge_oe(gack_oe),
      .o_address_strobe_n(as_n), .o_address_strobe_oe(as_oe),
      .i_size_ack(sa_bus), .o_size_ack(sa_dut), .o_size_ack_oe(sa_oe),
      .i_chip_select_n(cs_n), .i_slave_direction(dir), .i_reg_index(2'h0),
      .i_data(sdata), .o_data(odata), .o_data_oe(data_oe),
      .i_user_pins(upin_bus), .o_user_pins(upins),
      .o_user_pins_oe(upins_oe));

   bus_side_model MDL (
      .i_ref_clk(clk), .i_bus_request_n(br_bus),
      .i_address_strobe_n(as_bus), .i_ack_mode(ack_mode),
      .o_bus_grant_n(grant_n), .o_size_ack(sa_mdl));

   task summarize;
      $display("Comparisons %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   task chk_bit(input logic g, input logic e, input string m);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk_bit

   task chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk_word

   // A wait that used its whole bound ends the run
   task bounded(input int n);
      if (n >= 40) begin
         err_total++;
         summarize();
      end
   endtask : bounded

   task wait_ready;
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1 && n < 40) begin
         n++;
         @(posedge clk);
      end
      bounded(n);
   endtask : wait_ready

   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      chk_bit(hresp, 1'b0, "response not OKAY");
   endtask : ahb

   // One slave register access on the pin port, held until acknowledged
   task slave_acc(input logic d, input logic [15:0] wd,
                  output logic [15:0] rd);
      int n;
      @(posedge clk);
      cs_n  <= 1'b0;
      dir   <= d;
      sdata <= wd;
      for (n = 0; n < 40 && sa_oe !== 1'b1; n++) @(negedge clk);
      bounded(n);
      chk_word({30'h0, sa_dut}, 32'h0, "size acks not both low");
      chk_bit(data_oe, d, "data drive wrong for direction");
      if (d) chk_word({16'h0, odata[31:16]}, 32'h0, "upper data");
      rd = odata[15:0];
      @(posedge clk);
      cs_n <= 1'b1;
      for (n = 0; n < 40 && sa_oe !== 1'b0; n++) @(negedge clk);
      bounded(n);
   endtask : slave_acc

   task t_reset;
      logic [31:0] rd;
      @(posedge clk);
      @(negedge clk);
      chk_bit(gack_oe, 1'b0, "grant ack driven in reset");
      chk_bit(upins_oe, 1'b0, "user pins driven in reset");
      chk_bit(sa_oe, 1'b0, "size acks driven in reset");
      chk_bit(hready, 1'b1, "hreadyout low in reset");
      @(posedge clk);
      rst   <= 1'b0;
      pulls <= 2'b01; // Pins change after release; latch must hold
      ahb(1'b0, {28'h0, `OFS_CFG}, 32'h0, rd);
      chk_word(rd, 32'h0200, "latched user pins");
      chk_bit(upins_oe, 1'b0, "user pins driven when idle");
   endtask : t_reset

   task t_slave;
      logic [31:0] rd;
      logic [15:0] rd16;
      slave_acc(1'b0, 16'h1300, rd16);
      ahb(1'b0, {28'h0, `OFS_CFG}, 32'h0, rd);
      chk_word(rd, 32'h1200, "slave write or latch bits");
      slave_acc(1'b1, 16'h0, rd16);
      chk_word({16'h0, rd16}, 32'h1200, "slave read data");
      ahb(1'b1, 32'hc, 32'hffff, rd);
      ahb(1'b0, 32'hc, 32'h0, rd);
      chk_word(rd, 32'h0, "unmapped read");
   endtask : t_slave

   // Wrong acks must not end the cycle, the right ones must
   task cycle(input logic [1:0] wrong, input logic [1:0] right);
      int n;
      logic [31:0] rd;
      @(posedge clk);
      ack_mode <= wrong;
      ahb(1'b1, {28'h0, `OFS_CTRL}, 32'h3, rd);
      for (n = 0; n < 40 && as_bus !== 1'b0; n++) @(negedge clk);
      bounded(n);
      repeat (8) @(negedge clk);
      chk_bit(as_bus, 1'b0, "cycle ended on wrong acks");
      @(posedge clk);
      ack_mode <= right;
      for (n = 0; n < 40 && as_bus !== 1'b1; n++) @(negedge clk);
      bounded(n);
      chk_bit(as_bus, 1'b1, "cycle not ended");
   endtask : cycle

   task t_master;
      int n;
      logic [31:0] rd;
      ahb(1'b1, {28'h0, `OFS_CFG}, 32'h0c20, rd); // 32-bit, direct sampling
      other_gack_n <= 1'b0;
      ahb(1'b1, {28'h0, `OFS_CTRL}, 32'h1, rd);
      repeat (10) @(negedge clk);
      chk_bit(grant_n, 1'b0, "no grant");
      chk_bit(br_oe, 1'b1, "bus request not driven");
      chk_bit(gack_n, 1'b1, "claimed while other master owns");
      @(posedge clk);
      other_gack_n <= 1'b1;
      for (n = 0; n < 40 && gack_n !== 1'b0; n++) @(negedge clk);
      bounded(n);
      chk_bit(gack_oe, 1'b1, "grant ack not driven");
      repeat (2) @(negedge clk);
      chk_bit(upins_oe, 1'b1, "user pins not driven as master");
      chk_word({30'h0, upin_bus}, 32'h1, "user pin levels");
      cycle(2'b10, 2'b11);
      ahb(1'b1, {28'h0, `OFS_CFG}, 32'h1000, rd); // 16-bit, synchronisers
      cycle(2'b01, 2'b10);
      ahb(1'b0, {28'h0, `OFS_STAT}, 32'h0, rd);
      chk_word(rd, 32'h0201, "cycle count or owned flag");
      chk_word({30'h0, upin_bus}, 32'h2, "user pins follow config");
      ahb(1'b1, {28'h0, `OFS_CTRL}, 32'h0, rd);
      for (n = 0; n < 40 && gack_n !== 1'b1; n++) @(negedge clk);
      bounded(n);
      @(negedge clk);
      chk_bit(upins_oe, 1'b0, "user pins driven after release");
      @(posedge clk);
      hold_ack <= 1'b1;
      repeat (3) @(negedge clk);
      chk_bit(upins_oe, 1'b1, "user pins not driven on hold ack");
      @(posedge clk);
      hold_ack <= 1'b0;
      repeat (3) @(negedge clk);
      chk_bit(upins_oe, 1'b0, "user pins kept after hold ack");
   endtask : t_master

   // Hang guard, about 20000 cycles
   initial begin
      #2000000;
      err_total++;
      summarize();
   end

   initial begin
      t_reset();
      t_slave();
      t_master();
      summarize();
   end

endmodule : tb_host_bus_ack_and_user_pins
